// ===== pin_level_pkg.sv
// shared constants and carrier types for the pin level control block
package pin_level_pkg;
  localparam int ADDR_W = 23;
  localparam int LOW_ADDR_W = 16;
  localparam int DATA_W = 16;
  localparam int NUM_IRQ = 4;
  localparam logic [22:0] RESET_PC = 23'h00ff80;
  localparam logic [22:0] ROM_BASE = 23'h00c000;
  localparam logic [22:0] ROM_LIMIT = 23'h00ffff;
  localparam logic [15:0] USER_VEC_BASE = 16'hffc0;
  localparam logic [15:0] NMI_VEC = 16'hff88;
  // register offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_IRQ_PEND = 8'h04;
  localparam logic [7:0] OFS_IRQ_EN = 8'h08;
  localparam logic [7:0] OFS_CPU_OP = 8'h0c;
  localparam logic [7:0] OFS_ADDR = 8'h10;
  localparam logic [7:0] OFS_WDATA = 8'h14;
  localparam logic [7:0] OFS_STATUS = 8'h18;
  localparam logic [7:0] OFS_EVT = 8'h1c;
  localparam logic [7:0] OFS_EVT_MASK = 8'h20;
  // ctrl fields
  localparam int CTRL_GDIS = 0;
  localparam int CTRL_HOLDER = 1;
  localparam logic [1:0] CTRL_RST = 2'h1;
  // cpu op codes
  localparam logic [2:0] OP_NONE = 3'h0;
  localparam logic [2:0] OP_SETF = 3'h1;
  localparam logic [2:0] OP_CLRF = 3'h2;
  localparam logic [2:0] OP_LDST1 = 3'h3;
  localparam logic [2:0] OP_WRITE = 3'h4;
  localparam logic [2:0] OP_READ = 3'h5;
  localparam logic [2:0] OP_XC = 3'h6;
  localparam logic [2:0] OP_BC = 3'h7;
  // event bits
  localparam int EV_IRQ_ACCEPT_N = 0;
  localparam int EV_COND = 1;
  localparam int EV_HOLD = 2;
  localparam int NUM_EV = 3;

  typedef struct packed {
    logic [ADDR_W-1:0] out;
    logic [ADDR_W-1:0] oeN;
  } addr_pins_s;

  typedef struct packed {
    logic [DATA_W-1:0] out;
    logic [DATA_W-1:0] oeN;
  } data_pins_s;

  typedef enum logic [3:0] {
    ST_RESET = 4'b0001,
    ST_RUN = 4'b0010,
    ST_ACK = 4'b0100,
    ST_HOLD = 4'b1000
  } pin_state_e;
endpackage : pin_level_pkg

// ===== dsp_pin_level_control.sv
// pin level control: address/data buses, interrupts, flag and hold
`timescale 1ns/1ns
// Behaviour
// - low 16 address lines shared; upper 7 only for program space
// - all 23 address lines float during hold
// - output-off low floats address, data, acknowledge and flag
// - bus holder keeps last address level while floating
// - data bus driven only for write data; floats in reset or hold
// - data bus holders keep level, software enables or disables them
// - acknowledge asserted on interrupt accept, vector on low address
// - four user interrupts fixed priority, masked per bit and globally
// - pending user interrupts latched, software polls and clears
// - non-maskable interrupt taken regardless of masks, own vector
// - reset stops execution, counter at ff80, fetch resumes there
// - boot map sampled at reset; low maps ROM in upper 16K
// - conditional instruction executes when branch input low
// - branch input sampled in decode for xc, read otherwise
// - flag latched; set instruction high, clear low, status load takes bit 8
// - flag forced high during reset
// - hold request claims bus; device floats lines once granted
module dsp_pin_level_control (
  input wire logic clk,
  input wire logic resetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic chip_reset_n,
  input wire logic output_off_n,
  input wire logic hold_req_n,
  input wire logic boot_map_select,
  input wire logic branch_cond_in_n,
  input wire logic nmi_n,
  input wire logic [3:0] user_irq_lines,
  input wire logic [15:0] ext_data_in,
  output pin_level_pkg::addr_pins_s ext_addr_bus,
  output pin_level_pkg::data_pins_s ext_data_bus,
  output logic irq_accept_n,
  output logic irq_accept_oe_n,
  output logic sw_flag_out,
  output logic sw_flag_oe_n,
  output logic bus_grant_ack_n,
  output logic bus_grant_oe_n,
  output logic rom_mapped,
  output logic irq
);
  localparam int AW = pin_level_pkg::ADDR_W;
  localparam int DW = pin_level_pkg::DATA_W;

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  pin_level_pkg::pin_state_e state_ff, nxt_state;
  logic [1:0] ctrl_ff, readPipe_ff;
  logic [3:0] pend_ff, enable_ff;
  logic [2:0] evt_ff, evtMask_ff;
  logic [AW-1:0] addr_ff, pc_ff, busAddr_ff;
  logic [DW-1:0] wdata_ff, dataHold_ff, rdata_ff;
  logic flag_ff, romMap_ff, condTaken_ff, nmiPrev_ff, nmiPend_ff;
  logic [3:0] irqPrev_ff;
  logic driveData_ff, bcPend_ff;
  logic [15:0] vec_ff;
  logic [31:0] prdata_ff;
  logic pready_ff;

  // ----------------------------------------------------------------
  // apb decode
  // ----------------------------------------------------------------
  wire apbSetup = psel && !penable;
  wire apbDone = psel && penable && pready_ff;
  wire apbWr = apbDone && pwrite;
  wire apbRd = apbDone && !pwrite;
  wire hitCtrl = paddr == pin_level_pkg::OFS_CTRL;
  wire hitPend = paddr == pin_level_pkg::OFS_IRQ_PEND;
  wire hitEn = paddr == pin_level_pkg::OFS_IRQ_EN;
  wire hitOp = paddr == pin_level_pkg::OFS_CPU_OP;
  wire hitAddr = paddr == pin_level_pkg::OFS_ADDR;
  wire hitWdata = paddr == pin_level_pkg::OFS_WDATA;
  wire hitStat = paddr == pin_level_pkg::OFS_STATUS;
  wire hitEvt = paddr == pin_level_pkg::OFS_EVT;
  wire hitEvtM = paddr == pin_level_pkg::OFS_EVT_MASK;
  wire hitAny = hitCtrl | hitPend | hitEn | hitOp | hitAddr | hitWdata |
                hitStat | hitEvt | hitEvtM;
  wire [2:0] opCode = pwdata[2:0];
  wire opStrobe = apbWr && hitOp && state_ff == pin_level_pkg::ST_RUN;

  // ----------------------------------------------------------------
  // pin conditions
  // ----------------------------------------------------------------
  wire inReset = !chip_reset_n;
  wire offNow = !output_off_n;
  wire holdNow = state_ff == pin_level_pkg::ST_HOLD;
  wire addrFloat = holdNow || offNow || inReset;
  wire dataDrive = driveData_ff && !holdNow && !offNow && !inReset &&
                   hold_req_n;

  // ----------------------------------------------------------------
  // interrupt priority
  // ----------------------------------------------------------------
  wire [3:0] irqRise = ~user_irq_lines & irqPrev_ff;
  wire [3:0] live = pend_ff & enable_ff;
  wire userReady = |live && !ctrl_ff[pin_level_pkg::CTRL_GDIS];
  wire [1:0] winner = live[0] ? 2'd0 : live[1] ? 2'd1 : live[2] ? 2'd2 :
                      2'd3;
  wire takeNmi = nmiPend_ff;
  wire takeUser = userReady && !takeNmi;
  wire [3:0] winMask = 4'h1 << winner;
  wire [15:0] userVec = pin_level_pkg::USER_VEC_BASE +
                        {12'h000, winner, 2'b00};

  function automatic logic inRom(input logic [22:0] a, input logic m);
    inRom = m && a >= pin_level_pkg::ROM_BASE &&
            a <= pin_level_pkg::ROM_LIMIT;
  endfunction : inRom

  // ----------------------------------------------------------------
  // state machine
  // ----------------------------------------------------------------
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      pin_level_pkg::ST_RESET: nxt_state = pin_level_pkg::ST_RUN;
      pin_level_pkg::ST_RUN: begin
        if (!hold_req_n) nxt_state = pin_level_pkg::ST_HOLD;
        else if (takeNmi || takeUser) nxt_state = pin_level_pkg::ST_ACK;
      end
      pin_level_pkg::ST_ACK: nxt_state = pin_level_pkg::ST_RUN;
      pin_level_pkg::ST_HOLD: begin
        if (hold_req_n) nxt_state = pin_level_pkg::ST_RUN;
      end
      default: nxt_state = pin_level_pkg::ST_RESET;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!resetn || inReset) state_ff <= pin_level_pkg::ST_RESET;
    else state_ff <= nxt_state;
  end

  // ----------------------------------------------------------------
  // program counter and boot map
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!resetn || inReset) begin
      pc_ff <= pin_level_pkg::RESET_PC;
    end else if (state_ff == pin_level_pkg::ST_ACK) begin
      pc_ff <= {7'h00, vec_ff};
    end else if (state_ff == pin_level_pkg::ST_RUN && hold_req_n) begin
      pc_ff <= pc_ff + 23'h000001;
    end
  end

  // strap caught while reset is held, clocked
  always_ff @(posedge clk) begin
    if (!resetn) romMap_ff <= 1'b1;
    else if (inReset) romMap_ff <= !boot_map_select;
  end

  // ----------------------------------------------------------------
  // interrupt flags, vector, nmi edge
  // ----------------------------------------------------------------
  wire [3:0] pendClr = (apbWr && hitPend) ? pwdata[3:0] : 4'h0;
  wire [3:0] ackClr = takeUser && state_ff == pin_level_pkg::ST_RUN &&
                      hold_req_n ? winMask : 4'h0;
  always_ff @(posedge clk) begin
    if (!resetn || inReset) begin
      pend_ff <= 4'h0;
      irqPrev_ff <= 4'hf;
      nmiPrev_ff <= 1'b1;
      nmiPend_ff <= 1'b0;
      vec_ff <= 16'h0000;
    end else begin
      irqPrev_ff <= user_irq_lines;
      nmiPrev_ff <= nmi_n;
      pend_ff <= (pend_ff & ~pendClr & ~ackClr) | irqRise;
      if (!nmi_n && nmiPrev_ff) nmiPend_ff <= 1'b1;
      else if (state_ff == pin_level_pkg::ST_ACK && vec_ff ==
               pin_level_pkg::NMI_VEC) nmiPend_ff <= 1'b0;
      if (state_ff == pin_level_pkg::ST_RUN && hold_req_n) begin
        if (takeNmi) vec_ff <= pin_level_pkg::NMI_VEC;
        else if (takeUser) vec_ff <= userVec;
      end
    end
  end

  // ----------------------------------------------------------------
  // software registers and cpu operations
  // ----------------------------------------------------------------
  // xc tests the pin at decode, other tests one cycle later at read
  wire condEval = (opStrobe && opCode == pin_level_pkg::OP_XC) ||
                  bcPend_ff;
  always_ff @(posedge clk) begin
    if (!resetn) begin
      ctrl_ff <= pin_level_pkg::CTRL_RST;
      enable_ff <= 4'h0;
      addr_ff <= '0;
      wdata_ff <= '0;
      flag_ff <= 1'b1;
      condTaken_ff <= 1'b0;
      bcPend_ff <= 1'b0;
      evtMask_ff <= 3'h0;
    end else begin
      if (apbWr && hitCtrl) ctrl_ff <= pwdata[1:0];
      if (apbWr && hitEn) enable_ff <= pwdata[3:0];
      if (apbWr && hitAddr) addr_ff <= pwdata[AW-1:0];
      if (apbWr && hitWdata) wdata_ff <= pwdata[DW-1:0];
      if (apbWr && hitEvtM) evtMask_ff <= pwdata[2:0];
      if (inReset) flag_ff <= 1'b1;
      else if (opStrobe && opCode == pin_level_pkg::OP_SETF)
        flag_ff <= 1'b1;
      else if (opStrobe && (opCode == pin_level_pkg::OP_CLRF ||
               opCode == pin_level_pkg::OP_LDST1))
        flag_ff <= pwdata[8] && opCode == pin_level_pkg::OP_LDST1;
      bcPend_ff <= opStrobe && opCode == pin_level_pkg::OP_BC;
      if (condEval) condTaken_ff <= !branch_cond_in_n;
    end
  end

  // ----------------------------------------------------------------
  // bus address, data drive and holders
  // ----------------------------------------------------------------
  wire opAccess = opStrobe && (opCode == pin_level_pkg::OP_WRITE ||
                  opCode == pin_level_pkg::OP_READ);
  wire progSpace = pwdata[4];
  wire [AW-1:0] accAddr = progSpace ? addr_ff :
                          {7'h00, addr_ff[15:0]};
  always_ff @(posedge clk) begin
    if (!resetn) begin
      busAddr_ff <= pin_level_pkg::RESET_PC;
      driveData_ff <= 1'b0;
      dataHold_ff <= '0;
      rdata_ff <= '0;
      readPipe_ff <= 2'h0;
    end else begin
      if (state_ff == pin_level_pkg::ST_ACK)
        busAddr_ff <= {7'h00, vec_ff};
      else if (opAccess) busAddr_ff <= accAddr;
      driveData_ff <= opAccess && opCode == pin_level_pkg::OP_WRITE;
      // take read data once the new address stands on the pins
      readPipe_ff <= {readPipe_ff[0], opAccess &&
                      opCode == pin_level_pkg::OP_READ};
      if (readPipe_ff[1]) rdata_ff <= ext_data_in;
      if (dataDrive) dataHold_ff <= wdata_ff;
      else if (!ctrl_ff[pin_level_pkg::CTRL_HOLDER])
        dataHold_ff <= ext_data_in; // holder off: follow the wire
    end
  end

  // ----------------------------------------------------------------
  // pin outputs
  // ----------------------------------------------------------------
  wire [AW-1:0] nxtAddrOe = {AW{addrFloat}};
  wire holderOn = ctrl_ff[pin_level_pkg::CTRL_HOLDER];
  wire [AW-1:0] nxtAddrOut = state_ff == pin_level_pkg::ST_ACK ?
                             {7'h00, vec_ff} : busAddr_ff;
  always_ff @(posedge clk) begin
    if (!resetn) begin
      ext_addr_bus <= '{out: pin_level_pkg::RESET_PC, oeN: '1};
      ext_data_bus <= '{out: '0, oeN: '1};
      irq_accept_n <= 1'b1;
      irq_accept_oe_n <= 1'b1;
      sw_flag_out <= 1'b1;
      sw_flag_oe_n <= 1'b1;
      bus_grant_ack_n <= 1'b1;
      bus_grant_oe_n <= 1'b1;
    end else begin
      // out keeps last driven level while floated
      if (!addrFloat) ext_addr_bus.out <= nxtAddrOut;
      ext_addr_bus.oeN <= nxtAddrOe;
      ext_data_bus.out <= dataDrive ? wdata_ff : dataHold_ff;
      ext_data_bus.oeN <= {DW{!dataDrive}};
      irq_accept_n <= state_ff != pin_level_pkg::ST_ACK;
      irq_accept_oe_n <= offNow;
      sw_flag_out <= inReset ? 1'b1 : flag_ff;
      sw_flag_oe_n <= offNow;
      bus_grant_ack_n <= !holdNow;
      bus_grant_oe_n <= offNow;
    end
  end

  // ----------------------------------------------------------------
  // events, interrupt line, apb read
  // ----------------------------------------------------------------
  wire [2:0] evtSet = {!holdNow && nxt_state == pin_level_pkg::ST_HOLD,
                       condEval && !branch_cond_in_n,
                       state_ff == pin_level_pkg::ST_ACK};
  wire evtRd = apbRd && hitEvt;
  wire [31:0] rdMux =
    hitCtrl ? {30'h0, ctrl_ff} :
    hitPend ? {28'h0, pend_ff} :
    hitEn ? {28'h0, enable_ff} :
    hitAddr ? {9'h0, addr_ff} :
    hitWdata ? {16'h0, wdata_ff} :
    hitStat ? {rdata_ff, 7'h0, romMap_ff, condTaken_ff, flag_ff,
               state_ff, holderOn, 1'b0} :
    hitEvt ? {29'h0, evt_ff} :
    hitEvtM ? {29'h0, evtMask_ff} : 32'h0;
  always_ff @(posedge clk) begin
    if (!resetn) begin
      evt_ff <= 3'h0;
      pready_ff <= 1'b0;
      prdata_ff <= 32'h0;
      irq <= 1'b0;
      rom_mapped <= 1'b1;
      pslverr <= 1'b0;
    end else begin
      evt_ff <= (evtRd ? 3'h0 : evt_ff) | evtSet; // set beats clear
      pready_ff <= apbSetup;
      if (apbSetup) prdata_ff <= rdMux;
      pslverr <= apbSetup && !hitAny;
      irq <= |(evt_ff & evtMask_ff);
      rom_mapped <= romMap_ff;
    end
  end
  assign pready = pready_ff;
  assign prdata = prdata_ff;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  property p_addr_float;
    @(posedge clk) disable iff (!resetn)
    (holdNow || offNow) |=> ext_addr_bus.oeN == '1;
  endproperty
  a_addr_float: assert property (p_addr_float)
    else $error("address not floated");
  property p_off_float;
    @(posedge clk) disable iff (!resetn)
    offNow |=> irq_accept_oe_n && sw_flag_oe_n && ext_data_bus.oeN == '1;
  endproperty
  a_off_float: assert property (p_off_float)
    else $error("outputs not floated on off");
  property p_addr_keep;
    @(posedge clk) disable iff (!resetn)
    addrFloat |=> $stable(ext_addr_bus.out);
  endproperty
  a_addr_keep: assert property (p_addr_keep)
    else $error("address holder lost level");
  property p_data_float;
    @(posedge clk) disable iff (!resetn)
    (inReset || !hold_req_n) |=> ext_data_bus.oeN == '1;
  endproperty
  a_data_float: assert property (p_data_float)
    else $error("data driven in reset or hold");
  property p_ack_vec;
    @(posedge clk) disable iff (!resetn)
    state_ff == pin_level_pkg::ST_ACK && !addrFloat |=> !irq_accept_n &&
      ext_addr_bus.out[15:0] == $past(vec_ff);
  endproperty
  a_ack_vec: assert property (p_ack_vec)
    else $error("acknowledge without vector");
  property p_nmi_vec;
    @(posedge clk) disable iff (!resetn || inReset)
    state_ff == pin_level_pkg::ST_RUN && takeNmi && hold_req_n |=>
      vec_ff == pin_level_pkg::NMI_VEC;
  endproperty
  a_nmi_vec: assert property (p_nmi_vec)
    else $error("nmi vector wrong");
  property p_reset_pc;
    @(posedge clk) disable iff (!resetn)
    inReset |=> pc_ff == pin_level_pkg::RESET_PC && sw_flag_out;
  endproperty
  a_reset_pc: assert property (p_reset_pc)
    else $error("reset counter or flag wrong");
  property p_gmask;
    @(posedge clk) disable iff (!resetn || inReset)
    ctrl_ff[pin_level_pkg::CTRL_GDIS] && !takeNmi &&
      state_ff == pin_level_pkg::ST_RUN |=>
      state_ff != pin_level_pkg::ST_ACK;
  endproperty
  a_gmask: assert property (p_gmask)
    else $error("masked interrupt taken");
  property p_flag_set;
    @(posedge clk) disable iff (!resetn || inReset)
    opStrobe && opCode == pin_level_pkg::OP_SETF |=> ##1 sw_flag_out;
  endproperty
  a_flag_set: assert property (p_flag_set)
    else $error("flag not set");
  c_ack: cover property (@(posedge clk) disable iff (!resetn)
    !irq_accept_n);
  c_hold: cover property (@(posedge clk) disable iff (!resetn)
    !bus_grant_ack_n);
  c_write: cover property (@(posedge clk) disable iff (!resetn)
    ext_data_bus.oeN == '0);
endmodule : dsp_pin_level_control

// ===== ext_memory_model.sv
// behavioural external memory on the far side of the pin buses
`timescale 1ns/1ns
module ext_memory_model (
  input wire logic clk,
  input wire pin_level_pkg::addr_pins_s addrBus,
  input wire pin_level_pkg::data_pins_s dataBus,
  output logic [15:0] dataIn,
  output logic [15:0] lastWrite
);
  logic [15:0] mem [0:15];
  logic [15:0] lastLevel = 16'h0000;
  wire devDrives = dataBus.oeN == 16'h0000;
  wire memDrives = !devDrives && addrBus.oeN[15:0] == 16'h0000;
  // ---------------------------------
  // capture writes, resolve data wire
  // ---------------------------------
  always @(posedge clk) begin
    if (devDrives) begin
      mem[addrBus.out[3:0]] <= dataBus.out;
      lastWrite <= dataBus.out;
    end
    lastLevel <= dataIn;
  end
  // released wire shows the inverse of its level one clock earlier
  assign dataIn = devDrives ? dataBus.out :
    memDrives ? mem[addrBus.out[3:0]] : ~lastLevel;
endmodule : ext_memory_model

// ===== dsp_pin_level_control_bench.sv
// self-checking bench for the pin level control block
`timescale 1ns/1ns
module dsp_pin_level_control_bench;
  logic clk, resetn, psel, penable, pwrite, pready, pslverr, err, hit;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rdv, d, seed;
  logic chipResetN, outputOffN, holdReqN, bootMap, branchN, nmiN;
  logic irqAcceptN, irqAcceptOeN, swFlag, swFlagOeN, grantN, grantOeN;
  logic romMapped, irq;
  logic [3:0] userIrq, en, fire;
  logic [15:0] dataIn, lastWrite;
  logic [22:0] a, seenA, mask;
  pin_level_pkg::addr_pins_s addrBus;
  pin_level_pkg::data_pins_s dataBus;
  int cycles = 0;
  int mismatches = 0;
  int nCompared = 0;

  dsp_pin_level_control uut (
    .clk(clk), .resetn(resetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .chip_reset_n(chipResetN),
    .output_off_n(outputOffN), .hold_req_n(holdReqN),
    .boot_map_select(bootMap), .branch_cond_in_n(branchN), .nmi_n(nmiN),
    .user_irq_lines(userIrq), .ext_data_in(dataIn), .ext_addr_bus(addrBus),
    .ext_data_bus(dataBus), .irq_accept_n(irqAcceptN),
    .irq_accept_oe_n(irqAcceptOeN), .sw_flag_out(swFlag),
    .sw_flag_oe_n(swFlagOeN), .bus_grant_ack_n(grantN),
    .bus_grant_oe_n(grantOeN), .rom_mapped(romMapped), .irq(irq)
  );
  ext_memory_model memModel (
    .clk(clk), .addrBus(addrBus), .dataBus(dataBus), .dataIn(dataIn),
    .lastWrite(lastWrite)
  );

  // ---------------------------------
  // helpers
  // ---------------------------------
  task automatic giveVerdict();
    $display("compared %0d mismatches %0d", nCompared, mismatches);
    if (mismatches == 0 && nCompared > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : giveVerdict

  task automatic chk(input string what, input logic [31:0] exp,
                     input logic [31:0] got);
    nCompared++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic apb(input logic wr, input logic [7:0] ad,
                     input logic [31:0] wd);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= ad;
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rdv = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask : cyc

  task automatic pulse(input logic [3:0] f, input logic nmi);
    @(posedge clk);
    userIrq <= ~f;
    nmiN <= !nmi;
    repeat (2) @(posedge clk);
    userIrq <= 4'hf;
    nmiN <= 1'b1;
  endtask : pulse

  task automatic watchData(output logic drv, output logic [22:0] at);
    drv = 1'b0;
    at = '0;
    repeat (8) begin
      @(negedge clk);
      if (dataBus.oeN !== 16'hffff) begin
        drv = 1'b1;
        at = addrBus.out;
      end
    end
  endtask : watchData

  task automatic waitAck(input logic [15:0] vec, input logic want);
    logic seen;
    logic [15:0] got;
    seen = 1'b0;
    got = 16'h0000;
    repeat (40) begin
      @(negedge clk);
      if (!seen && irqAcceptN === 1'b0) begin
        seen = 1'b1;
        got = addrBus.out[15:0];
      end
    end
    chk("ackSeen", want, seen);
    if (want)
      chk("ackVector", vec, got);
  endtask : waitAck

  function automatic logic [15:0] vecOf(input logic [3:0] p);
    for (int n = 3; n >= 0; n--)
      if (p[n])
        vecOf = pin_level_pkg::USER_VEC_BASE + 16'(4 * n);
  endfunction : vecOf

  function automatic logic flagExp(input logic [31:0] op);
    if (op[2:0] == pin_level_pkg::OP_SETF)
      return 1'b1;
    if (op[2:0] == pin_level_pkg::OP_CLRF)
      return 1'b0;
    return op[8];
  endfunction : flagExp

  // ---------------------------------
  // clock and timeout
  // ---------------------------------
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      mismatches++;
      giveVerdict();
    end
  end

  // ---------------------------------
  // main sequence
  // ---------------------------------
  initial begin
    resetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    chipResetN = 1'b1;
    outputOffN = 1'b1;
    holdReqN = 1'b1;
    bootMap = 1'b0;
    branchN = 1'b1;
    nmiN = 1'b1;
    userIrq = 4'hf;
    seed = $urandom(39730);
    repeat (3) @(posedge clk);
    resetn <= 1'b1;
    for (int b = 0; b < 2; b++) begin
      apb(1, pin_level_pkg::OFS_CPU_OP, {29'h0, pin_level_pkg::OP_CLRF});
      @(posedge clk);
      bootMap <= b[0];
      chipResetN <= 1'b0;
      cyc(3);
      chk("flagInReset", 1, swFlag);
      chk("dataOeInReset", 16'hffff, dataBus.oeN);
      @(posedge clk);
      chipResetN <= 1'b1;
      cyc(3);
      chk("romMapped", !b[0], romMapped);
    end
    for (int i = 0; i < 4; i++) begin
      d = $urandom();
      d[2:0] = i == 0 ? pin_level_pkg::OP_SETF :
        i == 1 ? pin_level_pkg::OP_CLRF : pin_level_pkg::OP_LDST1;
      d[8] = i == 2;
      apb(1, pin_level_pkg::OFS_CPU_OP, d);
      cyc(3);
      chk("flag", flagExp(d), swFlag);
    end
    @(posedge clk);
    outputOffN <= 1'b0;
    cyc(3);
    chk("offFlag", 1, swFlagOeN);
    chk("offAck", 1, irqAcceptOeN);
    chk("offAddr", 23'h7fffff, addrBus.oeN);
    chk("offData", 16'hffff, dataBus.oeN);
    chk("offGrant", 1, grantOeN);
    @(posedge clk);
    outputOffN <= 1'b1;
    for (int k = 0; k < 4; k++) begin
      a = 23'($urandom());
      d = $urandom();
      apb(1, pin_level_pkg::OFS_ADDR, {9'h000, a});
      apb(1, pin_level_pkg::OFS_WDATA, d);
      apb(1, pin_level_pkg::OFS_CPU_OP, {27'h0, k[0], 1'b0, 3'h4});
      watchData(hit, seenA);
      mask = k[0] ? 23'h7fffff : 23'h00ffff;
      chk("wrDriven", 1, hit);
      chk("wrAddr", a & mask, seenA);
      chk("wrMem", d[15:0], lastWrite);
      chk("dataHeld", {d[15:0], 16'hffff}, dataBus);
      apb(1, pin_level_pkg::OFS_CPU_OP, {27'h0, k[0], 1'b0, 3'h5});
      cyc(6);
      apb(0, pin_level_pkg::OFS_STATUS, 32'h0);
      chk("rdData", d[15:0], rdv[31:16]);
    end
    @(posedge clk);
    holdReqN <= 1'b0;
    cyc(4);
    chk("grant", 0, grantN);
    chk("holdAddrOe", 23'h7fffff, addrBus.oeN);
    seenA = addrBus.out;
    apb(1, pin_level_pkg::OFS_CPU_OP, {29'h0, pin_level_pkg::OP_WRITE});
    watchData(hit, a);
    chk("holdDataFloat", 0, hit);
    chk("addrHeld", seenA, addrBus.out);
    @(posedge clk);
    holdReqN <= 1'b1;
    cyc(4);
    chk("grantOff", 1, grantN);
    apb(1, pin_level_pkg::OFS_CTRL, 32'h1);
    apb(1, pin_level_pkg::OFS_IRQ_EN, 32'hf);
    pulse(4'hf, 1'b0);
    waitAck(16'h0, 1'b0);
    apb(0, pin_level_pkg::OFS_IRQ_PEND, 32'h0);
    chk("pending", 4'hf, rdv[3:0]);
    apb(1, pin_level_pkg::OFS_IRQ_PEND, 32'h5);
    apb(0, pin_level_pkg::OFS_IRQ_PEND, 32'h0);
    chk("pendingCleared", 4'ha, rdv[3:0]);
    for (int t = 0; t < 6; t++) begin
      en = t == 0 ? 4'h5 : 4'($urandom());
      fire = t == 0 ? 4'ha : 4'($urandom_range(15, 1));
      apb(1, pin_level_pkg::OFS_IRQ_PEND, 32'hf);
      apb(1, pin_level_pkg::OFS_IRQ_EN, {28'h0, en});
      apb(1, pin_level_pkg::OFS_CTRL, 32'h0);
      pulse(fire, 1'b0);
      waitAck(vecOf(en & fire), (en & fire) != 4'h0);
      apb(1, pin_level_pkg::OFS_IRQ_EN, 32'h0);
      cyc(30);
    end
    apb(1, pin_level_pkg::OFS_CTRL, 32'h1);
    apb(1, pin_level_pkg::OFS_EVT_MASK, 32'h1);
    apb(0, pin_level_pkg::OFS_EVT, 32'h0);
    chk("holdEvent", 1, rdv[pin_level_pkg::EV_HOLD]);
    pulse(4'h0, 1'b1);
    waitAck(pin_level_pkg::NMI_VEC, 1'b1);
    chk("irqRaised", 1, irq);
    apb(0, pin_level_pkg::OFS_EVT, 32'h0);
    chk("ackEvent", 1, rdv[pin_level_pkg::EV_IRQ_ACCEPT_N]);
    cyc(2);
    chk("irqCleared", 0, irq);
    apb(1, pin_level_pkg::OFS_EVT_MASK, 32'h0);
    pulse(4'h0, 1'b1);
    waitAck(pin_level_pkg::NMI_VEC, 1'b1);
    chk("irqMasked", 0, irq);
    for (int c = 0; c < 4; c++) begin
      @(posedge clk);
      branchN <= c[0];
      apb(1, pin_level_pkg::OFS_CPU_OP, {29'h0, c[1] ? 3'h7 : 3'h6});
      branchN <= !c[0];
      cyc(4);
      apb(0, pin_level_pkg::OFS_STATUS, 32'h0);
      chk("cond", c[1] ? c[0] : !c[0], rdv[7]);
    end
    apb(0, pin_level_pkg::OFS_EVT, 32'h0);
    chk("condEvent", 1, rdv[pin_level_pkg::EV_COND]);
    apb(1, pin_level_pkg::OFS_CTRL, 32'h3);
    apb(0, pin_level_pkg::OFS_STATUS, 32'h0);
    chk("holderOn", 1, rdv[1]);
    chk("mappedOk", 0, err);
    apb(0, 8'h24, 32'h0);
    chk("unmapped", 1, err);
    giveVerdict();
  end
endmodule : dsp_pin_level_control_bench
